// ### design/fed_decoder.sv
/*
  Escape opcode decoder: takes an escape instruction (escape bits and
  mod-reg-r/m byte), collects its displacement bytes, forms the address,
  runs the execution budget and applies stack pointer and control effects.
  Assumes the host holds insnValid/dispValid only while ready/waiting and
  that all inputs are synchronous to core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fed_defs.svh"

module fed_decoder
  import fed_pkg::*;
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  // instruction issue
  input  wire logic                 insnValid,
  input  wire logic [2:0]           insnEsc,
  input  wire logic [7:0]           insnModrm,
  output logic                      insnReady,
  // displacement bytes
  input  wire logic                 dispValid,
  input  wire logic [7:0]           dispByte,
  // host base registers
  input  wire fed_pkg::fed_base_s   baseRegs,
  // decode results
  output fed_pkg::fed_dec_s         decoded,
  output logic [15:0]               effAddr,
  output logic [`FED_CNT_W-1:0]     clkBudget,
  output logic                      busy,
  output logic                      done,
  output logic                      undefOp,
  // stack and control state
  output logic [2:0]                stackTop,
  output logic                      irqMasked,
  output logic                      clearExc
);

  // ----------------------------------------------------------------
  // instruction field decode
  // ----------------------------------------------------------------
  logic [1:0]            modF;
  logic [2:0]            regF;
  logic [2:0]            rmF;
  fed_dec_s              dec;
  logic [`FED_CNT_W-1:0] budget;
  logic [1:0]            dispNeed;

  assign modF = insnModrm[7:6];
  assign regF = insnModrm[5:3];
  assign rmF  = insnModrm[2:0];

  always_comb begin
    dec          = '0;
    dec.opCode   = FED_OP_UNDEF;
    budget       = '0;
    dispNeed     = 2'd0;
    if (modF == `FED_MOD_REG) begin
      // r/m is a stack register index
      dec.stackIndex = rmF;
      if (!insnEsc[0]) begin
        unique case (regF)
          3'b000: dec.opCode = FED_OP_ADD;
          3'b001: dec.opCode = FED_OP_MUL;
          3'b100,
          3'b101: dec.opCode = FED_OP_SUB;
          3'b110,
          3'b111: dec.opCode = FED_OP_DIV;
          default: dec.opCode = FED_OP_UNDEF;
        endcase
        if (dec.opCode != FED_OP_UNDEF) begin
          dec.destIsIndex = insnEsc[2];
          dec.reverseOps  = regF[2] & (regF[0] ^ insnEsc[2]);
          dec.popTop      = insnEsc[1];
          budget = (dec.opCode == FED_OP_DIV) ? `FED_CLK_DIV : `FED_CLK_ADDSUB;
          if (insnEsc[1]) begin
            budget = budget + `FED_POP_EXTRA;
          end
        end
      end else if (insnEsc == `FED_ESC_XFN) begin
        unique case (insnModrm)
          `FED_RM_ABS: begin
            dec.opCode = FED_OP_ABS;
            budget     = `FED_CLK_ABS;
          end
          `FED_RM_CHS: begin
            dec.opCode = FED_OP_CHS;
            budget     = `FED_CLK_ABS;
          end
          `FED_RM_XTRACT: begin
            dec.opCode = FED_OP_XTRACT;
            budget     = `FED_CLK_XTRACT;
          end
          `FED_RM_SCALE: begin
            dec.opCode     = FED_OP_SCALE;
            dec.stackIndex = 3'd1;
            budget         = `FED_CLK_SCALE;
          end
          `FED_RM_PATAN: begin
            dec.opCode = FED_OP_PATAN;
            budget     = `FED_CLK_PATAN;
          end
          `FED_RM_YL2X: begin
            dec.opCode = FED_OP_YL2X;
            budget     = `FED_CLK_YL2X;
          end
          `FED_RM_INCSTP: begin
            dec.opCode = FED_OP_INCSTP;
            budget     = `FED_CLK_STP;
          end
          `FED_RM_DECSTP: begin
            dec.opCode = FED_OP_DECSTP;
            budget     = `FED_CLK_STP;
          end
          default: dec.opCode = FED_OP_UNDEF;
        endcase
      end else if (insnEsc == `FED_ESC_CTL) begin
        budget = `FED_CLK_CTL;
        unique case (insnModrm)
          `FED_RM_INIT: dec.opCode = FED_OP_INIT;
          `FED_RM_ENI:  dec.opCode = FED_OP_ENI;
          `FED_RM_DISI: dec.opCode = FED_OP_DISI;
          `FED_RM_CLEX: dec.opCode = FED_OP_CLEX;
          default: begin
            dec.opCode = FED_OP_UNDEF;
            budget     = '0;
          end
        endcase
      end
    end else begin
      dec.isMemory = 1'b1;
      if (!insnEsc[0]) begin
        dec.memFormat = fed_mf_e'(insnEsc[2:1]);
        dec.memRead   = 1'b1;
        unique case (regF[2:1])
          2'b00: dec.opCode = regF[0] ? FED_OP_MUL : FED_OP_ADD;
          2'b10: dec.opCode = FED_OP_SUB;
          2'b11: dec.opCode = FED_OP_DIV;
          default: dec.opCode = FED_OP_UNDEF;
        endcase
        dec.reverseOps = regF[2] & regF[0];
        if (dec.opCode != FED_OP_UNDEF) begin
          budget = `FED_CLK_ARITHM + `FED_EA_CLKS;
        end
      end else begin
        unique case ({insnEsc, regF})
          {`FED_ESC_XFN, `FED_REG_LDCW}: begin
            dec.opCode  = FED_OP_LDCW;
            dec.memRead = 1'b1;
            budget      = `FED_CLK_LDCW + `FED_EA_CLKS;
          end
          {`FED_ESC_XFN, `FED_REG_STCW}: begin
            dec.opCode   = FED_OP_STCW;
            dec.memWrite = 1'b1;
            budget       = `FED_CLK_STW + `FED_EA_CLKS;
          end
          {`FED_ESC_STATE, `FED_REG_STCW}: begin
            dec.opCode   = FED_OP_STSW;
            dec.memWrite = 1'b1;
            budget       = `FED_CLK_STW + `FED_EA_CLKS;
          end
          {`FED_ESC_STATE, `FED_REG_SAVE}: begin
            dec.opCode   = FED_OP_SAVE;
            dec.memWrite = 1'b1;
            budget       = `FED_CLK_STATE + `FED_EA_CLKS;
          end
          {`FED_ESC_STATE, `FED_REG_RSTOR}: begin
            dec.opCode  = FED_OP_RSTOR;
            dec.memRead = 1'b1;
            budget      = `FED_CLK_STATE + `FED_EA_CLKS;
          end
          default: dec.opCode = FED_OP_UNDEF;
        endcase
      end
      unique case (modF)
        `FED_MOD_DISP8:  dispNeed = 2'd1;
        `FED_MOD_DISP16: dispNeed = 2'd2;
        default:         dispNeed = (rmF == `FED_RM_DIRECT) ? 2'd2 : 2'd0;
      endcase
    end
    if (dec.opCode == FED_OP_UNDEF) begin
      dispNeed = 2'd0;
    end
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  fed_state_e            state_ff,  nxt_state;
  fed_dec_s              dec_ff,    nxt_dec;
  logic [1:0]            mod_ff,    nxt_mod;
  logic [2:0]            rm_ff,     nxt_rm;
  logic [1:0]            need_ff,   nxt_need;
  logic [15:0]           disp_ff,   nxt_disp;
  logic [15:0]           ea_ff,     nxt_ea;
  logic [`FED_CNT_W-1:0] budget_ff, nxt_budget;
  logic                  busy_ff,   nxt_busy;
  logic                  done_ff,   nxt_done;
  logic                  undef_ff,  nxt_undef;
  logic                  ready_ff,  nxt_ready;
  logic [2:0]            top_ff,    nxt_top;
  logic                  mask_ff,   nxt_mask;
  logic                  clex_ff,   nxt_clex;
  logic                  timerLoad;
  logic                  timerExpire;
  logic [15:0]           eaComb;

  // address fields of the instruction entering EXEC, also on a direct IDLE to EXEC step
  fed_ea_calc u_ea (
    .modField (nxt_mod),
    .rmField  (nxt_rm),
    .disp     (nxt_disp),
    .baseRegs (baseRegs),
    .effAddr  (eaComb)
  );

  fed_cycle_timer u_timer (
    .core_clk (core_clk),
    .nrst     (nrst),
    .load     (timerLoad),
    .count    (nxt_budget),
    .expire   (timerExpire)
  );

  always_comb begin
    nxt_state  = state_ff;
    nxt_dec    = dec_ff;
    nxt_mod    = mod_ff;
    nxt_rm     = rm_ff;
    nxt_need   = need_ff;
    nxt_disp   = disp_ff;
    nxt_ea     = ea_ff;
    nxt_budget = budget_ff;
    nxt_busy   = busy_ff;
    nxt_done   = 1'b0;
    nxt_undef  = 1'b0;
    nxt_top    = top_ff;
    nxt_mask   = mask_ff;
    nxt_clex   = 1'b0;
    timerLoad  = 1'b0;
    unique case (state_ff)
      FED_ST_IDLE: begin
        if (insnValid) begin
          if (dec.opCode == FED_OP_UNDEF) begin
            nxt_done  = 1'b1;
            nxt_undef = 1'b1;
          end else begin
            nxt_dec    = dec;
            nxt_mod    = modF;
            nxt_rm     = rmF;
            nxt_need   = dispNeed;
            nxt_budget = budget;
            nxt_busy   = 1'b1;
            nxt_disp   = 16'h0000;
            nxt_state  = (dispNeed != 2'd0) ? FED_ST_DISPLO : FED_ST_EXEC;
          end
        end
      end
      FED_ST_DISPLO: begin
        if (dispValid) begin
          if (need_ff == 2'd1) begin
            nxt_disp  = {{8{dispByte[7]}}, dispByte};
            nxt_state = FED_ST_EXEC;
          end else begin
            nxt_disp  = {8'h00, dispByte};
            nxt_state = FED_ST_DISPHI;
          end
        end
      end
      FED_ST_DISPHI: begin
        if (dispValid) begin
          nxt_disp  = {dispByte, disp_ff[7:0]};
          nxt_state = FED_ST_EXEC;
        end
      end
      FED_ST_EXEC: begin
        if (timerExpire) begin
          nxt_state = FED_ST_IDLE;
          nxt_busy  = 1'b0;
          nxt_done  = 1'b1;
          unique case (dec_ff.opCode)
            FED_OP_INCSTP: nxt_top = top_ff + 3'd1;
            FED_OP_DECSTP: nxt_top = top_ff - 3'd1;
            FED_OP_INIT: begin
              nxt_top  = 3'd0;
              nxt_mask = 1'b1;
            end
            FED_OP_ENI:  nxt_mask = 1'b0;
            FED_OP_DISI: nxt_mask = 1'b1;
            FED_OP_CLEX: nxt_clex = 1'b1;
            default: begin
              if (dec_ff.popTop) begin
                nxt_top = top_ff + 3'd1;
              end
            end
          endcase
        end
      end
    endcase
    if (nxt_state == FED_ST_EXEC && state_ff != FED_ST_EXEC) begin
      timerLoad = 1'b1;
      if (nxt_dec.isMemory) begin
        nxt_ea = eaComb;
      end
    end
    if (state_ff == FED_ST_IDLE && nxt_state != FED_ST_IDLE) begin
      nxt_mod = modF;
      nxt_rm  = rmF;
    end
    nxt_ready = (nxt_state == FED_ST_IDLE);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff  <= FED_ST_IDLE;
      dec_ff    <= '0;
      mod_ff    <= 2'b00;
      rm_ff     <= 3'b000;
      need_ff   <= 2'd0;
      disp_ff   <= 16'h0000;
      ea_ff     <= 16'h0000;
      budget_ff <= '0;
      busy_ff   <= 1'b0;
      done_ff   <= 1'b0;
      undef_ff  <= 1'b0;
      ready_ff  <= 1'b1;
      top_ff    <= 3'd0;
      mask_ff   <= 1'b1;
      clex_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      dec_ff    <= nxt_dec;
      mod_ff    <= nxt_mod;
      rm_ff     <= nxt_rm;
      need_ff   <= nxt_need;
      disp_ff   <= nxt_disp;
      ea_ff     <= nxt_ea;
      budget_ff <= nxt_budget;
      busy_ff   <= nxt_busy;
      done_ff   <= nxt_done;
      undef_ff  <= nxt_undef;
      ready_ff  <= nxt_ready;
      top_ff    <= nxt_top;
      mask_ff   <= nxt_mask;
      clex_ff   <= nxt_clex;
    end
  end

  assign insnReady = ready_ff;
  assign decoded   = dec_ff;
  assign effAddr   = ea_ff;
  assign clkBudget = budget_ff;
  assign busy      = busy_ff;
  assign done      = done_ff;
  assign undefOp   = undef_ff;
  assign stackTop  = top_ff;
  assign irqMasked = mask_ff;
  assign clearExc  = clex_ff;

endmodule : fed_decoder
`default_nettype wire

// ### design/fed_defs.svh
/*
  Constants of the escape opcode decoder: field codes, encodings and
  execution clock budgets. Assumes nothing beyond a single clock domain.
*/
`ifndef FED_DEFS_SVH
`define FED_DEFS_SVH

`define FED_CNT_W        11
`define FED_MOD_NODISP   2'b00
`define FED_MOD_DISP8    2'b01
`define FED_MOD_DISP16   2'b10
`define FED_MOD_REG      2'b11
`define FED_RM_DIRECT    3'b110

`define FED_ESC_XFN      3'b001
`define FED_ESC_CTL      3'b011
`define FED_ESC_STATE    3'b101

`define FED_RM_ABS       8'hE1
`define FED_RM_CHS       8'hE0
`define FED_RM_XTRACT    8'hF4
`define FED_RM_SCALE     8'hFD
`define FED_RM_PATAN     8'hF3
`define FED_RM_YL2X      8'hF1
`define FED_RM_INCSTP    8'hF7
`define FED_RM_DECSTP    8'hF6
`define FED_RM_INIT      8'hE3
`define FED_RM_ENI       8'hE0
`define FED_RM_DISI      8'hE1
`define FED_RM_CLEX      8'hE2
`define FED_REG_LDCW     3'b101
`define FED_REG_STCW     3'b111
`define FED_REG_SAVE     3'b110
`define FED_REG_RSTOR    3'b100

`define FED_POP_EXTRA    11'd5
`define FED_EA_CLKS      11'd12
`define FED_CLK_CTL      11'd8
`define FED_CLK_LDCW     11'd14
`define FED_CLK_STW      11'd18
`define FED_CLK_STATE    11'd207
`define FED_CLK_STP      11'd12
`define FED_CLK_ABS      11'd17
`define FED_CLK_SCALE    11'd38
`define FED_CLK_PATAN    11'd800
`define FED_CLK_YL2X     11'd1100
`define FED_CLK_XTRACT   11'd55
`define FED_CLK_ADDSUB   11'd100
`define FED_CLK_DIV      11'd203
`define FED_CLK_ARITHM   11'd143

`endif

// ### design/fed_pkg.sv
/*
  Types of the escape opcode decoder. Constants live in fed_defs.svh.
*/
package fed_pkg;

  typedef enum logic [4:0] {
    FED_OP_UNDEF  = 5'b00000,
    FED_OP_ADD    = 5'b00001,
    FED_OP_MUL    = 5'b00010,
    FED_OP_SUB    = 5'b00011,
    FED_OP_DIV    = 5'b00100,
    FED_OP_ABS    = 5'b00101,
    FED_OP_CHS    = 5'b00110,
    FED_OP_XTRACT = 5'b00111,
    FED_OP_SCALE  = 5'b01000,
    FED_OP_PATAN  = 5'b01001,
    FED_OP_YL2X   = 5'b01010,
    FED_OP_INCSTP = 5'b01011,
    FED_OP_DECSTP = 5'b01100,
    FED_OP_INIT   = 5'b01101,
    FED_OP_ENI    = 5'b01110,
    FED_OP_DISI   = 5'b01111,
    FED_OP_CLEX   = 5'b10000,
    FED_OP_LDCW   = 5'b10001,
    FED_OP_STCW   = 5'b10010,
    FED_OP_STSW   = 5'b10011,
    FED_OP_SAVE   = 5'b10100,
    FED_OP_RSTOR  = 5'b10101
  } fed_op_e;

  typedef enum logic [1:0] {
    FED_MF_REAL32 = 2'b00,
    FED_MF_INT32  = 2'b01,
    FED_MF_REAL64 = 2'b10,
    FED_MF_INT16  = 2'b11
  } fed_mf_e;

  typedef enum logic [1:0] {
    FED_ST_IDLE   = 2'b00,
    FED_ST_DISPLO = 2'b01,
    FED_ST_DISPHI = 2'b10,
    FED_ST_EXEC   = 2'b11
  } fed_state_e;

  typedef struct packed {
    fed_op_e    opCode;
    logic       isMemory;
    fed_mf_e    memFormat;
    logic       memRead;
    logic       memWrite;
    logic       destIsIndex;
    logic       popTop;
    logic       reverseOps;
    logic [2:0] stackIndex;
  } fed_dec_s;

  typedef struct packed {
    logic [15:0] bx;
    logic [15:0] si;
    logic [15:0] di;
    logic [15:0] bp;
  } fed_base_s;

endpackage : fed_pkg

// ### design/fed_ea_calc.sv
/*
  Effective address adder for the memory forms of the escape instructions.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fed_defs.svh"

module fed_ea_calc
  import fed_pkg::*;
(
  // addressing fields
  input  wire logic [1:0]       modField,
  input  wire logic [2:0]       rmField,
  input  wire logic [15:0]      disp,
  // base and index registers
  input  wire fed_pkg::fed_base_s baseRegs,
  // result
  output logic [15:0]           effAddr
);

  always_comb begin
    if (modField == `FED_MOD_NODISP && rmField == `FED_RM_DIRECT) begin
      effAddr = disp;
    end else begin
      unique case (rmField)
        3'b000: effAddr = 16'(baseRegs.bx + baseRegs.si + disp);
        3'b001: effAddr = 16'(baseRegs.bx + baseRegs.di + disp);
        3'b010: effAddr = 16'(baseRegs.bp + baseRegs.si + disp);
        3'b011: effAddr = 16'(baseRegs.bp + baseRegs.di + disp);
        3'b100: effAddr = 16'(baseRegs.si + disp);
        3'b101: effAddr = 16'(baseRegs.di + disp);
        3'b110: effAddr = 16'(baseRegs.bp + disp);
        3'b111: effAddr = 16'(baseRegs.bx + disp);
      endcase
    end
  end

endmodule : fed_ea_calc
`default_nettype wire

// ### design/fed_cycle_timer.sv
/*
  Execution budget counter. A load with a count of N gives an expiry
  pulse N cycles later. Assumes N is at least one.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fed_defs.svh"

module fed_cycle_timer (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  // control
  input  wire logic                 load,
  input  wire logic [`FED_CNT_W-1:0] count,
  // status
  output logic                      expire
);

  logic [`FED_CNT_W-1:0] cnt_ff;
  logic [`FED_CNT_W-1:0] nxt_cnt;

  assign expire = (cnt_ff == `FED_CNT_W'd1);

  always_comb begin
    nxt_cnt = cnt_ff;
    if (load) begin
      nxt_cnt = count;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - `FED_CNT_W'd1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : fed_cycle_timer
`default_nettype wire

// ### test/fed_decoder_chk.sv
/*
  Port checker of the escape decoder.
  Assumes one clock domain; bound to every fed_decoder below.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fed_defs.svh"

module fed_decoder_chk
  import fed_pkg::*;
(
  // watched ports
  input wire logic                   core_clk,
  input wire logic                   nrst,
  input wire logic                   insnValid,
  input wire logic [2:0]             insnEsc,
  input wire logic [7:0]             insnModrm,
  input wire logic                   insnReady,
  input wire logic                   dispValid,
  input wire fed_pkg::fed_dec_s      decoded,
  input wire logic [`FED_CNT_W-1:0]  clkBudget,
  input wire logic                   busy,
  input wire logic                   done,
  input wire logic                   undefOp,
  input wire logic [2:0]             stackTop,
  input wire logic                   irqMasked
);
  import fed_pkg::*;
  // ----------------------------------------
  // execution cycles since the last address byte
  // ----------------------------------------
  logic [`FED_CNT_W-1:0] cycCnt_ff;
  logic [`FED_CNT_W-1:0] nxt_cycCnt;

  always_comb begin
    nxt_cycCnt = (dispValid || !busy) ? '0 : cycCnt_ff + 1'b1;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cycCnt_ff <= '0;
    end else begin
      cycCnt_ff <= nxt_cycCnt;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence takeS;
    insnValid && insnReady;
  endsequence
  sequence startS;
    $rose(busy);
  endsequence

  pop_budget_a : assert property (
    takeS ##0 (insnEsc == 3'h2 && insnModrm[7:3] == 5'h18)
    |=> clkBudget == 11'h069 && decoded.popTop) else $error("pop budget wrong");
  stack_index_a : assert property (
    takeS ##0 (insnEsc == 3'h0 && insnModrm[7:3] == 5'h18)
    |=> decoded.stackIndex == $past(insnModrm[2:0])) else $error("stack index wrong");
  mem_format_a : assert property (
    takeS ##0 (insnModrm[7:6] != 2'h3 && !insnEsc[0] && insnModrm[5:3] == 3'h0)
    |=> decoded.isMemory && decoded.memFormat == $past(insnEsc[2:1]))
    else $error("memory format wrong");
  ctl_budget_a : assert property (
    startS ##0 (decoded.opCode inside {FED_OP_INIT, FED_OP_ENI, FED_OP_DISI, FED_OP_CLEX})
    |-> clkBudget == 11'h008) else $error("control budget wrong");
  abs_budget_a : assert property (
    startS ##0 (decoded.opCode inside {FED_OP_ABS, FED_OP_CHS})
    |-> clkBudget == 11'h011) else $error("sign op budget wrong");
  scale_budget_a : assert property (
    startS ##0 (decoded.opCode == FED_OP_SCALE)
    |-> clkBudget == 11'h026 && decoded.stackIndex == 3'h1) else $error("scale wrong");
  trans_budget_a : assert property (
    startS ##0 (decoded.opCode inside {FED_OP_PATAN, FED_OP_YL2X})
    |-> clkBudget == ((decoded.opCode == FED_OP_PATAN) ? 11'h320 : 11'h44C))
    else $error("transcendental budget wrong");
  run_length_a : assert property (
    done && !undefOp |-> cycCnt_ff == clkBudget) else $error("run length wrong");
  stack_step_a : assert property (
    done && !undefOp && decoded.opCode == FED_OP_DECSTP
    |-> stackTop == 3'($past(stackTop) - 3'h1)) else $error("stack step wrong");
  undef_quiet_a : assert property (
    undefOp |-> done && !busy && $stable(stackTop) && $stable(irqMasked))
    else $error("undefined op changed state");
endmodule : fed_decoder_chk

bind fed_decoder fed_decoder_chk i_chk (
  .core_clk(core_clk), .nrst(nrst), .insnValid(insnValid), .insnEsc(insnEsc),
  .insnModrm(insnModrm), .insnReady(insnReady), .dispValid(dispValid),
  .decoded(decoded), .clkBudget(clkBudget), .busy(busy), .done(done),
  .undefOp(undefOp), .stackTop(stackTop), .irqMasked(irqMasked)
);
`default_nettype wire

// ### test/fed_host_model.sv
/*
  Host side model: issues escape instructions and address bytes.
  Assumes the bench calls issue only while the decoder is idle.
*/
`timescale 1ns/100ps
`default_nettype none

module fed_host_model
  import fed_pkg::*;
(
  // clock
  input wire logic                core_clk,
  // decoder handshake
  input wire logic                insnReady,
  output var logic                insnValid,
  output var logic [2:0]          insnEsc,
  output var logic [7:0]          insnModrm,
  output var logic                dispValid,
  output var logic [7:0]          dispByte,
  output var fed_pkg::fed_base_s  baseRegs
);
  import fed_pkg::*;
  initial begin
    insnValid = 1'b0;
    insnEsc   = 3'h0;
    insnModrm = 8'h00;
    dispValid = 1'b0;
    dispByte  = 8'h00;
    baseRegs  = {16'h1000, 16'h0200, 16'h0030, 16'h4000};
  end

  task automatic issue(input logic [2:0] esc, input logic [7:0] modrm,
                       input int nDisp, input logic [15:0] disp);
    logic rdy;
    @(posedge core_clk);
    insnValid <= 1'b1;
    insnEsc   <= esc;
    insnModrm <= modrm;
    do begin
      @(negedge core_clk);
      rdy = insnReady;
      @(posedge core_clk);
    end while (!rdy);
    insnValid <= 1'b0;
    insnEsc   <= ~esc;
    insnModrm <= ~modrm;
    for (int i = 0; i < nDisp; i++) begin
      dispValid <= 1'b1;
      dispByte  <= disp[8*i +: 8];
      @(posedge core_clk);
    end
    dispValid <= 1'b0;
    dispByte  <= ~dispByte;
  endtask : issue
endmodule : fed_host_model
`default_nettype wire

// ### test/fed_decoder_tb.sv
/*
  Self-checking bench of the escape decoder.
  Assumes the host model and the bound checker are compiled beside it.
*/
`timescale 1ns/100ps
`default_nettype none

module fed_decoder_tb;
  import fed_pkg::*;
  logic core_clk, nrst, insnValid, insnReady, dispValid, busy, done, undefOp;
  logic irqMasked, clearExc;
  logic [2:0]  insnEsc, stackTop;
  logic [7:0]  insnModrm, dispByte;
  logic [15:0] effAddr;
  logic [10:0] clkBudget;
  fed_base_s   baseRegs;
  fed_dec_s    decoded;
  int          miscompares, compares;

  fed_decoder i_dut (.core_clk(core_clk), .nrst(nrst), .insnValid(insnValid),
    .insnEsc(insnEsc), .insnModrm(insnModrm), .insnReady(insnReady),
    .dispValid(dispValid), .dispByte(dispByte), .baseRegs(baseRegs), .decoded(decoded),
    .effAddr(effAddr), .clkBudget(clkBudget), .busy(busy), .done(done), .undefOp(undefOp),
    .stackTop(stackTop), .irqMasked(irqMasked), .clearExc(clearExc));
  fed_host_model i_host (.core_clk(core_clk), .insnReady(insnReady), .insnValid(insnValid),
    .insnEsc(insnEsc), .insnModrm(insnModrm), .dispValid(dispValid), .dispByte(dispByte),
    .baseRegs(baseRegs));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic run(input logic [2:0] esc, input logic [7:0] modrm,
                     input int nDisp, input logic [15:0] disp);
    int n;
    n = 0;
    i_host.issue(esc, modrm, nDisp, disp);
    do begin
      @(negedge core_clk);
      n++;
    end while (done !== 1'b1 && n < 1300);
    check("done", 1'b1, done);
  endtask : run

  task automatic t_budgets;
    logic [7:0]  m [12] = '{8'hE1, 8'hE0, 8'hF4, 8'hFD, 8'hF3, 8'hF1, 8'hF7, 8'hF6,
                            8'hE3, 8'hE0, 8'hE1, 8'hE2};
    logic [10:0] b [12] = '{11'h011, 11'h011, 11'h037, 11'h026, 11'h320, 11'h44C,
                            11'h00C, 11'h00C, 11'h008, 11'h008, 11'h008, 11'h008};
    for (int i = 0; i < 12; i++) begin
      run((i < 8) ? 3'h1 : 3'h3, m[i], 0, 16'h0000);
      check("clkBudget", b[i], clkBudget);
    end
  endtask : t_budgets

  task automatic t_stack;
    run(3'h3, 8'hE3, 0, 16'h0000);
    check("stackTop", 3'h0, stackTop);
    check("irqMasked", 1'b1, irqMasked);
    run(3'h3, 8'hE0, 0, 16'h0000);
    check("irqMasked", 1'b0, irqMasked);
    run(3'h1, 8'hF7, 0, 16'h0000);
    check("stackTop", 3'h1, stackTop);
    run(3'h1, 8'hF6, 0, 16'h0000);
    run(3'h1, 8'hF6, 0, 16'h0000);
    check("stackTop", 3'h7, stackTop);
    run(3'h2, 8'hC3, 0, 16'h0000);
    check("stackTop", 3'h0, stackTop);
    check("clkBudget", 11'h069, clkBudget);
    check("stackIndex", 3'h3, decoded.stackIndex);
    run(3'h3, 8'hE2, 0, 16'h0000);
    check("clearExc", 1'b1, clearExc);
    run(3'h3, 8'hE1, 0, 16'h0000);
    check("irqMasked", 1'b1, irqMasked);
  endtask : t_stack

  task automatic t_address;
    logic [2:0]  e [5] = '{3'h1, 3'h1, 3'h5, 3'h5, 3'h1};
    logic [7:0]  m [5] = '{8'h28, 8'h6F, 8'hBA, 8'h26, 8'h7D};
    int          n [5] = '{0, 1, 2, 2, 1};
    logic [15:0] d [5] = '{16'hFFFF, 16'h0080, 16'h1234, 16'hABCD, 16'h007F};
    logic [15:0] a [5] = '{16'h1200, 16'h0F80, 16'h5434, 16'hABCD, 16'h00AF};
    logic [10:0] b [5] = '{11'h01A, 11'h01A, 11'h01E, 11'h0DB, 11'h01E};
    for (int i = 0; i < 5; i++) begin
      run(e[i], m[i], n[i], d[i]);
      check("effAddr", a[i], effAddr);
      check("clkBudget", b[i], clkBudget);
      check("memWrite", m[i][4], decoded.memWrite);
    end
  endtask : t_address

  task automatic t_format;
    for (int i = 0; i < 4; i++) begin
      run({i[1:0], 1'b0}, 8'h04, 0, 16'h0000);
      check("memFormat", i[1:0], decoded.memFormat);
      check("effAddr", 16'h0200, effAddr);
    end
    run(3'h4, 8'hEA, 0, 16'h0000);
    check("destIsIndex", 1'b1, decoded.destIsIndex);
    check("reverseOps", 1'b0, decoded.reverseOps);
    run(3'h0, 8'hEA, 0, 16'h0000);
    check("reverseOps", 1'b1, decoded.reverseOps);
    run(3'h0, 8'hC5, 0, 16'h0000);
    check("stackIndex", 3'h5, decoded.stackIndex);
  endtask : t_format

  task automatic t_undef;
    logic [2:0] top;
    logic       msk;
    top = stackTop;
    msk = irqMasked;
    run(3'h0, 8'hD1, 0, 16'h0000);
    check("undefOp", 1'b1, undefOp);
    check("stackTop", top, stackTop);
    check("irqMasked", msk, irqMasked);
    check("busy", 1'b0, busy);
  endtask : t_undef

  task automatic stop_test;
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    miscompares = 0;
    compares = 0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    check("insnReady", 1'b1, insnReady);
    t_budgets();
    t_stack();
    t_address();
    t_format();
    t_undef();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    stop_test();
  end
endmodule : fed_decoder_tb
`default_nettype wire
